// ---- common/arwt_params.svh ----
// constants of the auto-reload watchdog timer
`ifndef ARWT_PARAMS_SVH
`define ARWT_PARAMS_SVH
`define ARWT_ADDR_COUNT 3'h0
`define ARWT_ADDR_RELOAD 3'h1
`define ARWT_ADDR_CTRL 3'h2
`define ARWT_ADDR_IRQ 3'h3
`define ARWT_CS_LSB 0
`define ARWT_RUN_BIT 3
`define ARWT_ONE_BIT 4
`define ARWT_WDRUN_BIT 5
`define ARWT_NEXT_BIT 6
`define ARWT_MODE_BIT 7
`define ARWT_CTRL_RESET 8'h10
`define ARWT_CODE_A 4'h3
`define ARWT_CODE_B 4'hC
`define ARWT_IRQ_VECTOR 16'h0042
`define ARWT_RESET_VECTOR 16'h0004
`define ARWT_IRQ_REQ_BIT 0
`define ARWT_IRQ_EN_BIT 1
`define ARWT_PRIO_LO_BIT 2
`define ARWT_PRIO_HI_BIT 3
`endif

// ---- common/arwt_pkg.sv ----
// types of the auto-reload watchdog timer
package arwt_pkg;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} arwt_bus_t;
	typedef enum logic [1:0] {
		ARWT_AUTO,
		ARWT_WD_ARMED,
		ARWT_WD_COUNT
	} arwt_mode_t;
endpackage

// ---- core/arwt_timer.sv ----
// auto-reload / watchdog 8-bit timer
// What this block does
// - counter write in auto-reload mode also loads reload register
// - bits 0-2 pick clock, bit 3 runs
// - control bit 7 selects watchdog mode
// - low nibble 3 starts watchdog, count kept
// - alternate C and 3 codes reload counter
// - bit 6 shows next expected code
// - counts each selected tick while running
// - overflow reloads counter, raises request only in auto mode
// - watchdog mode sticks until system reset
// - watchdog overflow resets system, vector 0004
// - timeout is ticks times 256 minus reload
// - auto overflow sets request flag
// - request forwarded only when enabled
// - two priority bits choose level
// - watchdog running ignores plain counter writes
// - reload read-only in watchdog mode
// - bit 5 reads one while watchdog counts
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "arwt_params.svh"
module arwt_timer #(
	parameter int SEL_W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire arwt_pkg::arwt_bus_t bus,
	output logic [7:0] rdata,
	// prescaled count ticks, one per selection
	input wire logic [(1<<SEL_W)-1:0] tick_in,
	// interrupt and system reset
	output logic irq,
	output logic [1:0] irq_priority,
	output logic [15:0] irq_vector,
	output logic sys_reset,
	output logic [15:0] reset_vector
);
	logic [7:0] count_value_reg;
	logic [7:0] reload_value_reg;
	logic [SEL_W-1:0] count_clock_select_reg;
	logic autoreload_run_reg;
	logic next_refresh_code_flag_reg;
	logic overflow_irq_request_reg;
	logic overflow_irq_enable_reg;
	logic [1:0] prio_reg;
	logic sys_reset_reg;
	arwt_pkg::arwt_mode_t mode_reg;
	logic tick;
	logic ovf;
	logic wr_count;
	logic wr_reload;
	logic wr_ctrl;
	logic wr_irq;
	logic code_ok;
	logic wd_mode;
	logic counting;

	function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] ref_a);
		hit = strobe && (a == ref_a);
	endfunction

	assign wr_count = hit(bus.wr, bus.addr, `ARWT_ADDR_COUNT);
	assign wr_reload = hit(bus.wr, bus.addr, `ARWT_ADDR_RELOAD);
	assign wr_ctrl = hit(bus.wr, bus.addr, `ARWT_ADDR_CTRL);
	assign wr_irq = hit(bus.wr, bus.addr, `ARWT_ADDR_IRQ);
	assign wd_mode = (mode_reg != arwt_pkg::ARWT_AUTO);
	assign tick = tick_in[count_clock_select_reg];
	assign counting = (mode_reg == arwt_pkg::ARWT_WD_COUNT) ||
		(!wd_mode && autoreload_run_reg);
	assign ovf = counting && tick && (count_value_reg == 8'hFF);
	// flag 0 expects low nibble 3, flag 1 expects C
	assign code_ok = next_refresh_code_flag_reg ?
		(bus.wdata[3:0] == `ARWT_CODE_B) : (bus.wdata[3:0] == `ARWT_CODE_A);

	// mode state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_reg <= arwt_pkg::ARWT_AUTO;
		end else begin
			case (mode_reg)
				arwt_pkg::ARWT_AUTO: begin
					if (wr_ctrl && bus.wdata[`ARWT_MODE_BIT]) begin
						mode_reg <= arwt_pkg::ARWT_WD_ARMED;
					end
				end
				arwt_pkg::ARWT_WD_ARMED: begin
					if (wr_count && bus.wdata[3:0] == `ARWT_CODE_A) begin
						mode_reg <= arwt_pkg::ARWT_WD_COUNT;
					end
				end
				arwt_pkg::ARWT_WD_COUNT: begin
					mode_reg <= arwt_pkg::ARWT_WD_COUNT;
				end
				default: begin
					mode_reg <= arwt_pkg::ARWT_AUTO;
				end
			endcase
		end
	end

	// control fields
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_clock_select_reg <= '0;
			autoreload_run_reg <= 1'b0;
		end else if (wr_ctrl && !wd_mode) begin
			count_clock_select_reg <= bus.wdata[SEL_W-1:0];
			autoreload_run_reg <= bus.wdata[`ARWT_RUN_BIT];
		end
	end

	// refresh code toggle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			next_refresh_code_flag_reg <= 1'b0;
		end else if (mode_reg == arwt_pkg::ARWT_WD_ARMED && wr_count &&
			bus.wdata[3:0] == `ARWT_CODE_A) begin
			next_refresh_code_flag_reg <= 1'b1;
		end else if (mode_reg == arwt_pkg::ARWT_WD_COUNT && wr_count && code_ok) begin
			next_refresh_code_flag_reg <= !next_refresh_code_flag_reg;
		end
	end

	// counter
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_value_reg <= 8'h00;
		end else if (mode_reg == arwt_pkg::ARWT_WD_COUNT && wr_count && code_ok) begin
			count_value_reg <= reload_value_reg;
		end else if (wr_count && !wd_mode) begin
			count_value_reg <= bus.wdata;
		end else if (ovf) begin
			count_value_reg <= reload_value_reg;
		end else if (counting && tick) begin
			count_value_reg <= count_value_reg + 8'h01;
		end
	end

	// reload register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reload_value_reg <= 8'h00;
		end else if (!wd_mode && (wr_count || wr_reload)) begin
			reload_value_reg <= bus.wdata;
		end
	end

	// interrupt flags; set wins over clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			overflow_irq_request_reg <= 1'b0;
			overflow_irq_enable_reg <= 1'b0;
			prio_reg <= 2'b00;
		end else begin
			if (ovf && !wd_mode) begin
				overflow_irq_request_reg <= 1'b1;
			end else if (wr_irq) begin
				overflow_irq_request_reg <= bus.wdata[`ARWT_IRQ_REQ_BIT];
			end
			if (wr_irq) begin
				overflow_irq_enable_reg <= bus.wdata[`ARWT_IRQ_EN_BIT];
				prio_reg <= {bus.wdata[`ARWT_PRIO_HI_BIT], bus.wdata[`ARWT_PRIO_LO_BIT]};
			end
		end
	end

	// watchdog system reset pulse
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sys_reset_reg <= 1'b0;
		end else begin
			sys_reset_reg <= ovf && (mode_reg == arwt_pkg::ARWT_WD_COUNT);
		end
	end

	// read data
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				`ARWT_ADDR_COUNT: rdata <= count_value_reg;
				`ARWT_ADDR_RELOAD: rdata <= reload_value_reg;
				`ARWT_ADDR_CTRL: rdata <= {wd_mode, next_refresh_code_flag_reg,
					mode_reg == arwt_pkg::ARWT_WD_COUNT, 1'b1, autoreload_run_reg,
					count_clock_select_reg};
				`ARWT_ADDR_IRQ: rdata <= {4'h0, prio_reg[1], prio_reg[0],
					overflow_irq_enable_reg, overflow_irq_request_reg};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	assign irq = overflow_irq_request_reg && overflow_irq_enable_reg;
	assign irq_priority = prio_reg;
	assign irq_vector = `ARWT_IRQ_VECTOR;
	assign sys_reset = sys_reset_reg;
	assign reset_vector = `ARWT_RESET_VECTOR;

	// ticks since the last refresh or overflow, watched by the timeout check
	logic [8:0] wd_ticks_reg;
	logic wd_timed_reg;
	logic wd_restart;
	logic wd_activate;
	assign wd_restart = (mode_reg == arwt_pkg::ARWT_WD_COUNT) && (ovf || (wr_count && code_ok));
	assign wd_activate = (mode_reg == arwt_pkg::ARWT_WD_ARMED) && wr_count &&
		(bus.wdata[3:0] == `ARWT_CODE_A);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wd_ticks_reg <= 9'h000;
			wd_timed_reg <= 1'b0;
		end else if (wd_restart) begin
			wd_ticks_reg <= 9'h000;
			wd_timed_reg <= 1'b1;
		end else if (mode_reg == arwt_pkg::ARWT_WD_COUNT && tick) begin
			wd_ticks_reg <= wd_ticks_reg + 9'h001;
		end
	end

	// watchdog mode entry and stickiness
	mode_sticky_a: assert property (@(posedge clk) disable iff (reset)
		wd_mode |=> wd_mode)
		else $error("watchdog mode left");
	count_sticky_a: assert property (@(posedge clk) disable iff (reset)
		(mode_reg == arwt_pkg::ARWT_WD_COUNT) |=> (mode_reg == arwt_pkg::ARWT_WD_COUNT))
		else $error("watchdog counting stopped");
	enter_wd_a: assert property (@(posedge clk) disable iff (reset)
		(!wd_mode && wr_ctrl && bus.wdata[`ARWT_MODE_BIT]) |=>
		(mode_reg == arwt_pkg::ARWT_WD_ARMED))
		else $error("watchdog mode not entered");
	stay_auto_a: assert property (@(posedge clk) disable iff (reset)
		(!wd_mode && !wr_ctrl) |=> !wd_mode)
		else $error("auto-reload mode left unasked");
	activate_a: assert property (@(posedge clk) disable iff (reset)
		wd_activate |=> (mode_reg == arwt_pkg::ARWT_WD_COUNT) && $stable(count_value_reg))
		else $error("activation wrong");
	armed_wait_a: assert property (@(posedge clk) disable iff (reset)
		(mode_reg == arwt_pkg::ARWT_WD_ARMED && !wd_activate) |=>
		(mode_reg == arwt_pkg::ARWT_WD_ARMED))
		else $error("watchdog started without code");
	armed_flag_a: assert property (@(posedge clk) disable iff (reset)
		wd_activate |=> next_refresh_code_flag_reg)
		else $error("activation left wrong expected code");

	// control register fields
	ctrl_write_a: assert property (@(posedge clk) disable iff (reset)
		(wr_ctrl && !wd_mode) |=> (count_clock_select_reg == $past(bus.wdata[SEL_W-1:0])) &&
		(autoreload_run_reg == $past(bus.wdata[`ARWT_RUN_BIT])))
		else $error("control write not taken");
	ctrl_lock_a: assert property (@(posedge clk) disable iff (reset)
		(wr_ctrl && wd_mode) |=> $stable(count_clock_select_reg) && $stable(autoreload_run_reg))
		else $error("control changed in watchdog mode");

	// counter
	count_step_a: assert property (@(posedge clk) disable iff (reset)
		(counting && tick && !ovf && !wr_count) |=>
		(count_value_reg == $past(count_value_reg) + 8'h01))
		else $error("no increment");
	halt_hold_a: assert property (@(posedge clk) disable iff (reset)
		(!counting && !wr_count) |=> $stable(count_value_reg))
		else $error("counter moved while halted");
	auto_reload_a: assert property (@(posedge clk) disable iff (reset)
		(ovf && !wr_count) |=> (count_value_reg == $past(reload_value_reg)))
		else $error("overflow did not reload");
	copy_reload_a: assert property (@(posedge clk) disable iff (reset)
		(wr_count && !wd_mode) |=> (reload_value_reg == $past(bus.wdata)) &&
		(count_value_reg == $past(bus.wdata)))
		else $error("counter write not copied");
	refresh_load_a: assert property (@(posedge clk) disable iff (reset)
		(mode_reg == arwt_pkg::ARWT_WD_COUNT && wr_count && code_ok) |=>
		(count_value_reg == $past(reload_value_reg)))
		else $error("refresh did not reload");
	refresh_toggle_a: assert property (@(posedge clk) disable iff (reset)
		(mode_reg == arwt_pkg::ARWT_WD_COUNT && wr_count && code_ok) |=>
		(next_refresh_code_flag_reg != $past(next_refresh_code_flag_reg)))
		else $error("refresh did not toggle expected code");
	bad_code_a: assert property (@(posedge clk) disable iff (reset)
		(mode_reg == arwt_pkg::ARWT_WD_COUNT && wr_count && !code_ok) |=>
		$stable(next_refresh_code_flag_reg))
		else $error("bad code toggled flag");
	bad_count_a: assert property (@(posedge clk) disable iff (reset)
		(mode_reg == arwt_pkg::ARWT_WD_COUNT && wr_count && !code_ok && !tick) |=>
		$stable(count_value_reg))
		else $error("bad code changed counter");
	flag_hold_a: assert property (@(posedge clk) disable iff (reset)
		!wr_count |=> $stable(next_refresh_code_flag_reg))
		else $error("expected code moved without write");

	// reload register
	reload_write_a: assert property (@(posedge clk) disable iff (reset)
		(wr_reload && !wd_mode) |=> (reload_value_reg == $past(bus.wdata)))
		else $error("reload write not taken");
	reload_lock_a: assert property (@(posedge clk) disable iff (reset)
		(wd_mode && $past(wd_mode)) |-> $stable(reload_value_reg))
		else $error("reload changed in watchdog");

	// interrupt flags
	irq_set_a: assert property (@(posedge clk) disable iff (reset)
		(ovf && !wd_mode) |=> overflow_irq_request_reg)
		else $error("request not set");
	irq_gate_a: assert property (@(posedge clk) disable iff (reset)
		(wr_irq && !bus.wdata[`ARWT_IRQ_EN_BIT]) |=> !irq)
		else $error("irq without enable");
	irq_clear_a: assert property (@(posedge clk) disable iff (reset)
		(wr_irq && !bus.wdata[`ARWT_IRQ_REQ_BIT] && !ovf) |=> !overflow_irq_request_reg)
		else $error("request not cleared");
	wd_no_irq_a: assert property (@(posedge clk) disable iff (reset)
		(wd_mode && !wr_irq) |=> $stable(overflow_irq_request_reg))
		else $error("request moved in watchdog mode");
	prio_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_irq |=>
		(irq_priority == $past({bus.wdata[`ARWT_PRIO_HI_BIT], bus.wdata[`ARWT_PRIO_LO_BIT]})))
		else $error("priority not taken");

	// system reset
	wd_reset_a: assert property (@(posedge clk) disable iff (reset)
		(ovf && mode_reg == arwt_pkg::ARWT_WD_COUNT) |=> sys_reset)
		else $error("no system reset");
	auto_no_reset_a: assert property (@(posedge clk) disable iff (reset)
		(mode_reg != arwt_pkg::ARWT_WD_COUNT) |=> !sys_reset)
		else $error("system reset outside watchdog");
	timeout_len_a: assert property (@(posedge clk) disable iff (reset)
		(ovf && wd_timed_reg && mode_reg == arwt_pkg::ARWT_WD_COUNT) |->
		(wd_ticks_reg + 9'h001 == 9'h100 - {1'b0, reload_value_reg}))
		else $error("watchdog timeout length wrong");

	// read data
	rd_idle_a: assert property (@(posedge clk) disable iff (reset)
		!bus.rd |=> (rdata == 8'h00))
		else $error("read data not idle");
	count_read_a: assert property (@(posedge clk) disable iff (reset)
		(bus.rd && bus.addr == `ARWT_ADDR_COUNT) |=> (rdata == $past(count_value_reg)))
		else $error("counter read wrong");
	reload_read_a: assert property (@(posedge clk) disable iff (reset)
		(bus.rd && bus.addr == `ARWT_ADDR_RELOAD) |=> (rdata == $past(reload_value_reg)))
		else $error("reload read wrong");
	ctrl_read_a: assert property (@(posedge clk) disable iff (reset)
		(bus.rd && bus.addr == `ARWT_ADDR_CTRL) |=> rdata[`ARWT_ONE_BIT] &&
		(rdata[`ARWT_WDRUN_BIT] == $past(mode_reg == arwt_pkg::ARWT_WD_COUNT)))
		else $error("control read wrong");
	next_read_a: assert property (@(posedge clk) disable iff (reset)
		(bus.rd && bus.addr == `ARWT_ADDR_CTRL) |=>
		(rdata[`ARWT_NEXT_BIT] == $past(next_refresh_code_flag_reg)))
		else $error("expected code read wrong");
	mode_read_a: assert property (@(posedge clk) disable iff (reset)
		(bus.rd && bus.addr == `ARWT_ADDR_CTRL) |=> (rdata[`ARWT_MODE_BIT] == $past(wd_mode)))
		else $error("mode bit read wrong");
endmodule

// ---- bench/tb_top.sv ----
// register-level testbench of the auto-reload watchdog timer
`timescale 1ns/1ns
`include "arwt_params.svh"
module tb_top;
	logic clk;
	logic reset;
	arwt_pkg::arwt_bus_t bus;
	logic [7:0] rdata;
	logic [7:0] tick_in;
	logic irq;
	logic [1:0] irq_priority;
	logic [15:0] irq_vector;
	logic sys_reset;
	logic [15:0] reset_vector;
	int n_errors = 0;
	int check_count = 0;
	int sr_cnt = 0;
	arwt_timer u_arwt_timer (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
		.tick_in(tick_in), .irq(irq), .irq_priority(irq_priority), .irq_vector(irq_vector),
		.sys_reset(sys_reset), .reset_vector(reset_vector));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// counts system reset pulses
	always @(posedge clk) if (sys_reset === 1'b1) sr_cnt <= sr_cnt + 1;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string msg);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk({8'h00, rdata}, {8'h00, exp}, msg);
	endtask
	task automatic tick(input int sel, input int n);
		repeat (n) begin
			@(posedge clk);
			tick_in <= 8'h01 << sel;
			@(posedge clk);
			tick_in <= 8'h00;
		end
	endtask
	task automatic do_reset();
		reset <= 1'b1;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		bus = '0;
		tick_in = 8'h00;
		do_reset();
		rd(`ARWT_ADDR_CTRL, 8'h10, "ctrl reset");
		wr(`ARWT_ADDR_CTRL, 8'h70);
		rd(`ARWT_ADDR_CTRL, 8'h10, "ctrl bits 4-6");
		rd(3'h5, 8'h00, "unmapped");
		$display("test reset done");
		wr(`ARWT_ADDR_COUNT, 8'hFE);
		rd(`ARWT_ADDR_RELOAD, 8'hFE, "reload copy");
		wr(`ARWT_ADDR_RELOAD, 8'h55);
		rd(`ARWT_ADDR_RELOAD, 8'h55, "reload rw");
		wr(`ARWT_ADDR_IRQ, 8'h0E);
		wr(`ARWT_ADDR_CTRL, 8'h0A);
		rd(`ARWT_ADDR_CTRL, 8'h1A, "ctrl run");
		tick(3, 1);
		rd(`ARWT_ADDR_COUNT, 8'hFE, "other tick");
		tick(2, 1);
		rd(`ARWT_ADDR_COUNT, 8'hFF, "count up");
		chk({15'h0000, irq}, 16'h0000, "irq early");
		tick(2, 1);
		rd(`ARWT_ADDR_COUNT, 8'h55, "reload on overflow");
		rd(`ARWT_ADDR_IRQ, 8'h0F, "request flag");
		chk({15'h0000, irq}, 16'h0001, "irq");
		chk({14'h0000, irq_priority}, 16'h0003, "priority");
		chk(irq_vector, `ARWT_IRQ_VECTOR, "vector");
		wr(`ARWT_ADDR_IRQ, 8'h0D);
		#1;
		chk({15'h0000, irq}, 16'h0000, "irq masked");
		wr(`ARWT_ADDR_CTRL, 8'h02);
		tick(2, 2);
		rd(`ARWT_ADDR_COUNT, 8'h55, "halted");
		$display("test auto-reload done");
		wr(`ARWT_ADDR_COUNT, 8'hF0);
		wr(`ARWT_ADDR_CTRL, 8'h81);
		rd(`ARWT_ADDR_CTRL, 8'h91, "wd mode");
		wr(`ARWT_ADDR_COUNT, 8'h23);
		rd(`ARWT_ADDR_COUNT, 8'hF0, "arm keeps count");
		rd(`ARWT_ADDR_CTRL, 8'hF1, "armed flags");
		wr(`ARWT_ADDR_CTRL, 8'h00);
		wr(`ARWT_ADDR_RELOAD, 8'h11);
		rd(`ARWT_ADDR_CTRL, 8'hF1, "mode sticks");
		rd(`ARWT_ADDR_RELOAD, 8'hF0, "reload ro");
		wr(`ARWT_ADDR_COUNT, 8'h13);
		rd(`ARWT_ADDR_CTRL, 8'hF1, "wrong code");
		tick(1, 3);
		rd(`ARWT_ADDR_COUNT, 8'hF3, "wd counts");
		wr(`ARWT_ADDR_COUNT, 8'h5C);
		rd(`ARWT_ADDR_COUNT, 8'hF0, "refresh C");
		rd(`ARWT_ADDR_CTRL, 8'hB1, "next code 3");
		tick(1, 2);
		wr(`ARWT_ADDR_COUNT, 8'h77);
		rd(`ARWT_ADDR_COUNT, 8'hF2, "plain write");
		wr(`ARWT_ADDR_COUNT, 8'hA3);
		rd(`ARWT_ADDR_CTRL, 8'hF1, "next code C");
		tick(1, 15);
		chk(16'(sr_cnt), 16'h0000, "early reset");
		tick(1, 1);
		for (int i = 0; i < 8 && sr_cnt == 0; i++) @(posedge clk);
		if (sr_cnt == 0) begin
			n_errors++;
			$display("CHECK FAILED at %0t: no system reset", $time);
		end else begin
			repeat (3) @(posedge clk);
			chk(16'(sr_cnt), 16'h0001, "one reset pulse");
			chk(reset_vector, `ARWT_RESET_VECTOR, "reset vector");
			do_reset();
			rd(`ARWT_ADDR_CTRL, 8'h10, "ctrl after sys reset");
		end
		$display("test watchdog done");
		final_report();
	end
endmodule
